/* File: hw/gpomx_top.sv */
// output multiplexer, driver control and apb register block for general-purpose pin six
`default_nettype none
module gpomx_top (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESET_N_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [gpomx_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [gpomx_pkg::DATA_W-1:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic PREADY_O,
	output logic [gpomx_pkg::DATA_W-1:0] PRDATA_O,
	output logic PSLVERR_O,
	// receive port status, bit n belongs to port n; remote gpio bits 4n to 4n+3 belong to port n
	input wire logic [gpomx_pkg::RX_PORTS*gpomx_pkg::RX_GPIOS-1:0] RX_REMOTE_GPIO_I,
	input wire logic [gpomx_pkg::RX_PORTS-1:0] RX_LOCK_I,
	input wire logic [gpomx_pkg::RX_PORTS-1:0] RX_PASS_I,
	input wire logic [gpomx_pkg::RX_PORTS-1:0] RX_FRAME_VALID_I,
	input wire logic [gpomx_pkg::RX_PORTS-1:0] RX_LINE_VALID_I,
	// device-wide frame sync
	input wire logic FRAME_SYNC_PULSE_I,
	// csi-2 transmit port status, bit n belongs to port n
	input wire logic [gpomx_pkg::TX_PORTS-1:0] TX_FRAME_VALID_I,
	input wire logic [gpomx_pkg::TX_PORTS-1:0] TX_LINE_VALID_I,
	input wire logic [gpomx_pkg::TX_PORTS-1:0] TX_SYNCED_I,
	input wire logic [gpomx_pkg::TX_PORTS-1:0] TX_IRQ_I,
	// pin six driver
	output logic GPIO6_LEVEL_O,
	output logic GPIO6_OE_N_O
);
	import gpomx_pkg::*;

	// register state
	logic [7:0] ctl_q;
	logic [7:0] ctl_d;
	logic [RX_PORTS-1:0] rx_en_q;
	logic [RX_PORTS-1:0] rx_en_d;
	logic [7:0] tx_sel_q;
	logic [7:0] tx_sel_d;
	logic pready_q;
	logic pready_d;
	logic [DATA_W-1:0] prdata_q;
	logic [DATA_W-1:0] prdata_d;
	logic pslverr_q;
	logic pslverr_d;
	logic level_q;
	logic level_d;
	logic oe_n_q;
	logic oe_n_d;

	// two-stage synchroniser on every status input
	logic [SYNC_W-1:0] sync_raw;
	logic [SYNC_W-1:0] sync_meta_q;
	logic [SYNC_W-1:0] sync_q;

	// synchronised views
	logic [RX_PORTS*RX_GPIOS-1:0] rx_gpio_s;
	logic [RX_PORTS-1:0] rx_lock_s;
	logic [RX_PORTS-1:0] rx_pass_s;
	logic [RX_PORTS-1:0] rx_fv_s;
	logic [RX_PORTS-1:0] rx_lv_s;
	logic frame_sync_s;
	logic [TX_PORTS-1:0] tx_fv_s;
	logic [TX_PORTS-1:0] tx_lv_s;
	logic [TX_PORTS-1:0] tx_sync_s;
	logic [TX_PORTS-1:0] tx_irq_s;

	// control fields
	logic [2:0] fn_sel;
	logic [2:0] src_sel;
	logic static_level;
	logic drive_en;

	// multiplexer candidates
	logic [7:0] rx_word [RX_PORTS];
	logic [7:0] tx_word [TX_PORTS];
	logic rx_val;
	logic dev_val;
	logic tx_val;
	logic lock_or;
	logic pass_and;

	// source class decode
	logic src_is_rx;
	logic src_is_status;
	logic src_is_tx;

	// bus decode
	logic access;
	logic wr_lane0;
	logic hit_ctl;
	logic hit_en;
	logic hit_txsel;
	logic hit_stat;
	logic hit_any;
	logic [DATA_W-1:0] rd_mux;

	// read words, narrow registers padded in the high bits
	logic [DATA_W-1:0] ctl_word;
	logic [DATA_W-1:0] en_word;
	logic [DATA_W-1:0] txsel_word;
	logic [DATA_W-1:0] stat_word;

	// address match, used once per register
	function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		logic [ADDR_W-1:0] byte_addr;
		byte_addr = ADDR_W'({idx, 2'b00});
		addr_is = (addr == byte_addr);
	endfunction : addr_is

	// and over the ports a mask picks; an empty mask reads as true
	function automatic logic masked_and(input logic [RX_PORTS-1:0] vec, input logic [RX_PORTS-1:0] mask);
		masked_and = &(vec | ~mask);
	endfunction : masked_and

	// or over the ports a mask picks; an empty mask reads as false
	function automatic logic masked_or(input logic [RX_PORTS-1:0] vec, input logic [RX_PORTS-1:0] mask);
		masked_or = |(vec & mask);
	endfunction : masked_or

	// bundle of inputs crossing into the core clock
	assign sync_raw = {TX_IRQ_I, TX_SYNCED_I, TX_LINE_VALID_I, TX_FRAME_VALID_I, FRAME_SYNC_PULSE_I,
		RX_LINE_VALID_I, RX_FRAME_VALID_I, RX_PASS_I, RX_LOCK_I, RX_REMOTE_GPIO_I};

	// first stage feeds only the second stage
	// a status pulse shorter than one clock may be missed; frame sync must be held longer
	// the bits are independent levels, so no gray code is needed across the crossing
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESET_N_I) begin
			sync_meta_q <= '0;
			sync_q <= '0;
		end else begin
			sync_meta_q <= sync_raw;
			sync_q <= sync_meta_q;
		end
	end

	// unpack the synchronised bundle
	// rx line valid crosses with the rest, but no function code on this pin routes it
	assign {tx_irq_s, tx_sync_s, tx_lv_s, tx_fv_s, frame_sync_s,
		rx_lv_s, rx_fv_s, rx_pass_s, rx_lock_s, rx_gpio_s} = sync_q;

	// control fields
	assign fn_sel = ctl_q[FN_SEL_LSB +: 3];
	assign src_sel = ctl_q[SRC_SEL_LSB +: 3];
	assign static_level = ctl_q[STATIC_LEVEL_BIT];
	assign drive_en = ctl_q[DRIVE_EN_BIT];

	// per receive port signal table, indexed by function code
	generate
		for (genvar p = 0; p < RX_PORTS; p++) begin : g_rx
			// code 111 left low
			// function code indexes this byte directly
			assign rx_word[p] = {1'b0, rx_fv_s[p], rx_pass_s[p], rx_lock_s[p],
				rx_gpio_s[p*RX_GPIOS +: RX_GPIOS]};
		end
	endgenerate

	// per transmit port signal table; pass select nibble picks rx ports
	generate
		for (genvar t = 0; t < TX_PORTS; t++) begin : g_tx
			logic [RX_PORTS-1:0] pick;
			assign pick = tx_sel_q[t*RX_PORTS +: RX_PORTS];
			// pass and/or, frame and line valid
			// synced, interrupt, reserved low
			// code 110 is undocumented and 111 reserved; both read low
			assign tx_word[t] = {1'b0, 1'b0, tx_irq_s[t], tx_sync_s[t], tx_lv_s[t], tx_fv_s[t],
				masked_or(rx_pass_s, pick), masked_and(rx_pass_s, pick)};
		end
	endgenerate

	// selected receive port
	// low two source bits name the rx port
	assign rx_val = rx_word[src_sel[1:0]][fn_sel];

	// enabled-port aggregates
	// with no port enabled the or reads low and the and reads high
	assign lock_or = masked_or(rx_lock_s, rx_en_q);
	assign pass_and = masked_and(rx_pass_s, rx_en_q);

	// device status selection
	// status code 011 repeats the pass and; 101 to 111 read low
	// static register level
	assign dev_val = (fn_sel == DEV_FN_STATIC) ? static_level :
		(fn_sel == DEV_FN_LOCK_OR) ? lock_or :
		(fn_sel == DEV_FN_PASS_AND || fn_sel == DEV_FN_PASS_AND_ALT) ? pass_and :
		(fn_sel == DEV_FN_FRAME_SYNC) ? frame_sync_s : 1'b0;

	// selected transmit port
	// bit 0 of the source names the tx port
	assign tx_val = tx_word[src_sel[0]][fn_sel];

	assign src_is_rx = (src_sel[2] == 1'b0);
	assign src_is_status = (src_sel == SRC_DEVICE_STATUS);
	// codes 110 and 111 both name a transmit port; bit 0 says which
	assign src_is_tx = (src_sel[2:1] == 2'b11);

	assign level_d = src_is_rx ? rx_val :
		src_is_status ? dev_val :
		src_is_tx ? tx_val : 1'b0;

	assign oe_n_d = ~drive_en;

	// pin flops keep the pad free of mux glitches
	// the level flop follows the mux while undriven, so enabling shows a settled value
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESET_N_I) begin
			level_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			level_q <= level_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign GPIO6_LEVEL_O = level_q;
	assign GPIO6_OE_N_O = oe_n_q;

	// apb decode; one wait state so all bus outputs come from flops
	// an access counts only once ready is up, so a write lands at the completing edge
	assign access = PSEL_I & PENABLE_I & pready_q;
	assign wr_lane0 = access & PWRITE_I & PSTRB_I[0];
	assign hit_ctl = addr_is(PADDR_I, PIN6_OUTPUT_CONTROL_IDX);
	assign hit_en = addr_is(PADDR_I, RX_PORT_ENABLE_IDX);
	assign hit_txsel = addr_is(PADDR_I, TX_PASS_SELECT_IDX);
	assign hit_stat = addr_is(PADDR_I, PIN6_STATUS_IDX);
	assign hit_any = hit_ctl | hit_en | hit_txsel | hit_stat;

	// read words, narrow registers in the low bits
	assign ctl_word = {24'h000000, ctl_q};
	assign en_word = {28'h0000000, rx_en_q};
	assign txsel_word = {24'h000000, tx_sel_q};
	// status shows synced lock, the pin level and whether the pin is driven
	assign stat_word = {26'h0, rx_lock_s, level_q, ~oe_n_q};

	// read data select; unmapped addresses read zero
	assign rd_mux = hit_ctl ? ctl_word :
		hit_en ? en_word :
		hit_txsel ? txsel_word :
		hit_stat ? stat_word : 32'h00000000;

	// answer one cycle into the access phase
	// ready drops the cycle after it rises, so a held access never completes on two cycles in a row
	assign pready_d = PSEL_I & PENABLE_I & ~pready_q;
	assign prdata_d = (pready_d & ~PWRITE_I) ? rd_mux : 32'h00000000;
	assign pslverr_d = pready_d & ~hit_any;

	// a completed write loads the addressed control, enable or select register; status ignores writes; a control write enables or disables the driver
	// only lane 0 carries register bits; the other strobes are ignored
	assign ctl_d = (wr_lane0 && hit_ctl) ? PWDATA_I[7:0] : ctl_q;
	assign rx_en_d = (wr_lane0 && hit_en) ? PWDATA_I[RX_PORTS-1:0] : rx_en_q;
	assign tx_sel_d = (wr_lane0 && hit_txsel) ? PWDATA_I[7:0] : tx_sel_q;

	// register flops; control fields clear so the pin starts undriven
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESET_N_I) begin
			ctl_q <= PIN6_OUTPUT_CONTROL_RST;
			rx_en_q <= RX_PORT_ENABLE_RST;
			tx_sel_q <= TX_PASS_SELECT_RST;
		end else begin
			ctl_q <= ctl_d;
			rx_en_q <= rx_en_d;
			tx_sel_q <= tx_sel_d;
		end
	end

	// bus answer flops; ready lasts one cycle, data and error ride with it
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESET_N_I) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= pready_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign PREADY_O = pready_q;
	assign PRDATA_O = prdata_q;
	assign PSLVERR_O = pslverr_q;

endmodule : gpomx_top
`default_nettype wire

/* File: hw/gpomx_pkg.sv */
// constants for the pin-six output multiplexer and its register block
`default_nettype none
package gpomx_pkg;
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register indices; byte address is four times the index
	localparam logic [7:0] PIN6_OUTPUT_CONTROL_IDX = 8'h16;
	localparam logic [7:0] RX_PORT_ENABLE_IDX = 8'h20;
	localparam logic [7:0] TX_PASS_SELECT_IDX = 8'h21;
	localparam logic [7:0] PIN6_STATUS_IDX = 8'h22;
	// field positions of pin6_output_control
	localparam int FN_SEL_LSB = 5;
	localparam int SRC_SEL_LSB = 2;
	localparam int STATIC_LEVEL_BIT = 1;
	localparam int DRIVE_EN_BIT = 0;
	// values after reset
	localparam logic [7:0] PIN6_OUTPUT_CONTROL_RST = 8'h00;
	localparam logic [3:0] RX_PORT_ENABLE_RST = 4'hF;
	localparam logic [7:0] TX_PASS_SELECT_RST = 8'hFF;
	// port counts
	localparam int RX_PORTS = 4;
	localparam int TX_PORTS = 2;
	localparam int RX_GPIOS = 4;
	// output source codes
	localparam logic [2:0] SRC_DEVICE_STATUS = 3'h4;
	localparam logic [2:0] SRC_RESERVED = 3'h5;
	// device-status function codes
	localparam logic [2:0] DEV_FN_STATIC = 3'h0;
	localparam logic [2:0] DEV_FN_LOCK_OR = 3'h1;
	localparam logic [2:0] DEV_FN_PASS_AND = 3'h2;
	localparam logic [2:0] DEV_FN_PASS_AND_ALT = 3'h3;
	localparam logic [2:0] DEV_FN_FRAME_SYNC = 3'h4;
	// width of the synchronised input bundle
	localparam int SYNC_W = RX_PORTS * (RX_GPIOS + 4) + 1 + TX_PORTS * 4;
endpackage : gpomx_pkg
`default_nettype wire

/* File: sim/gpomx_sva.sv */
// port assertions for the pin-six output multiplexer
`default_nettype none
module gpomx_sva (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESET_N_I,
	// apb side
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [gpomx_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [gpomx_pkg::DATA_W-1:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	input wire logic PREADY_O,
	input wire logic [gpomx_pkg::DATA_W-1:0] PRDATA_O,
	input wire logic PSLVERR_O,
	// pin driver
	input wire logic GPIO6_LEVEL_O,
	input wire logic GPIO6_OE_N_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	// completed transfers and control writes
	wire logic done = PSEL_I && PENABLE_I && PREADY_O;
	wire logic wr = done && PWRITE_I && PSTRB_I[0] && PADDR_I == 8'h58;
	wire logic mapped = PADDR_I inside {8'h58, 8'h80, 8'h84, 8'h88};
	property p_rst; $rose(RESET_N_I) |-> GPIO6_OE_N_O && !GPIO6_LEVEL_O && !PREADY_O; endproperty
	a_rst: assert property (p_rst) else $error("pin not idle after reset");
	property p_one; PREADY_O |=> !PREADY_O; endproperty
	a_one: assert property (p_one) else $error("ready longer than one cycle");
	property p_wait; PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I |=> PREADY_O; endproperty
	a_wait: assert property (p_wait) else $error("ready not after one wait state");
	property p_err; done |-> PSLVERR_O == !mapped; endproperty
	a_err: assert property (p_err) else $error("error flag wrong for address");
	property p_errq; PSLVERR_O |-> PREADY_O; endproperty
	a_errq: assert property (p_errq) else $error("error flag without ready");
	property p_idle; !PREADY_O |-> PRDATA_O == '0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside ready");
	property p_oe; wr |-> ##2 GPIO6_OE_N_O == !$past(PWDATA_I[0], 2); endproperty
	a_oe: assert property (p_oe) else $error("driver enable not as written");
	property p_lvl; wr && PWDATA_I[7:2] == 6'h04 |-> ##2 GPIO6_LEVEL_O == $past(PWDATA_I[1], 2); endproperty
	a_lvl: assert property (p_lvl) else $error("static level not routed");
	property p_rsv; wr && PWDATA_I[4:2] == 3'h5 |-> ##2 !GPIO6_LEVEL_O; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved source not low");
endmodule : gpomx_sva
`default_nettype wire

/* File: sim/gpomx_pin_peer.sv */
// far-side logic that samples pin six
`default_nettype none
module gpomx_pin_peer (
	// clock
	input wire logic clk_i,
	// pin driver
	input wire logic level_i,
	input wire logic oe_n_i,
	// level seen on the wire
	output logic seen_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// pull-down wins when the pin is undriven, so a stale level never shows
	always_ff @(posedge clk_i) begin
		seen_o <= oe_n_i ? 1'b0 : level_i;
	end
endmodule : gpomx_pin_peer
`default_nettype wire

/* File: sim/gpomx_top_bench.sv */
// self-checking bench for the pin-six output multiplexer
`default_nettype none
module gpomx_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, fs, lvl, oe_n, seen, rdy, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwd = 0, prd;
	logic [3:0] pstrb = 4'hF, lk, ps, fv, lv;
	logic [15:0] rg;
	logic [1:0] tfv, tlv, tsy, tir;
	int bad_count = 0, check_count = 0, cyc = 0;
	// 25 MHz core clock
	always #20 clk = ~clk;
	gpomx_top i_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwd), .PSTRB_I(pstrb), .PREADY_O(rdy), .PRDATA_O(prd), .PSLVERR_O(err),
		.RX_REMOTE_GPIO_I(rg), .RX_LOCK_I(lk), .RX_PASS_I(ps), .RX_FRAME_VALID_I(fv), .RX_LINE_VALID_I(lv),
		.FRAME_SYNC_PULSE_I(fs), .TX_FRAME_VALID_I(tfv), .TX_LINE_VALID_I(tlv), .TX_SYNCED_I(tsy),
		.TX_IRQ_I(tir), .GPIO6_LEVEL_O(lvl), .GPIO6_OE_N_O(oe_n));
	gpomx_pin_peer i_peer (.clk_i(clk), .level_i(lvl), .oe_n_i(oe_n), .seen_o(seen));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	// one apb transfer; the answer is taken at the rising edge where ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		r = prd;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic drive(input logic [40:0] k);
		{rg, lk, ps, fv, lv, tfv, tlv, tsy, tir, fs} <= k;
	endtask : drive
	// reference mux for enables 0x6 and tx selection 0x9C
	function automatic logic exp_lvl(input int s, input int f, input logic v);
		logic [3:0] sl;
		sl = (s == 7) ? 4'h9 : 4'hC;
		if (s < 4) return f < 4 ? rg[s*4+f] : f == 4 ? lk[s] : f == 5 ? ps[s] : f == 6 ? fv[s] : 1'b0;
		if (s == 4) return f == 0 ? v : f == 1 ? |(lk & 4'h6) : f < 4 ? &(ps | 4'h9) : f == 4 ? fs : 1'b0;
		if (s == 5) return 1'b0;
		return f == 0 ? &(ps | ~sl) : f == 1 ? |(ps & sl) : f == 2 ? tfv[s-6] : f == 3 ? tlv[s-6] :
			f == 4 ? tsy[s-6] : f == 5 ? tir[s-6] : 1'b0;
	endfunction : exp_lvl
	task automatic t_regs;
		logic [31:0] r;
		logic e;
		chk("oe_n", oe_n, 32'h1);
		chk("lvl", lvl, 32'h0);
		apb(1'b0, 8'h58, 32'h0, r, e);
		chk("ctl", r, 32'h0);
		chk("err map", e, 32'h0);
		apb(1'b0, 8'h80, 32'h0, r, e);
		chk("rx_en", r, 32'hF);
		apb(1'b0, 8'h84, 32'h0, r, e);
		chk("tx_sel", r, 32'hFF);
		apb(1'b1, 8'h5C, 32'h1, r, e);
		chk("err", e, 32'h1);
		pstrb <= 4'h0;
		apb(1'b1, 8'h58, 32'h1, r, e);
		chk("err strb", e, 32'h0);
		pstrb <= 4'hF;
		apb(1'b0, 8'h58, 32'h0, r, e);
		chk("ctl kept", r, 32'h0);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_sweep;
		logic [31:0] r;
		logic e;
		apb(1'b1, 8'h80, 32'h6, r, e);
		apb(1'b1, 8'h84, 32'h9C, r, e);
		apb(1'b0, 8'h80, 32'h0, r, e);
		chk("rx_en wr", r, 32'h6);
		apb(1'b0, 8'h84, 32'h0, r, e);
		chk("tx_sel wr", r, 32'h9C);
		for (int k = 0; k < 2; k++) begin
			drive(k ? ~41'h0A5C396E1B4 : 41'h0A5C396E1B4);
			for (int s = 0; s < 8; s++) begin
				for (int f = 0; f < 8; f++) begin
					apb(1'b1, 8'h58, 32'(f * 32 + s * 4 + 1 + k * 2), r, e);
					repeat (3) @(posedge clk);
					chk("pin", seen, exp_lvl(s, f, k[0]));
				end
			end
		end
		$display("t_sweep done");
	endtask : t_sweep
	task automatic t_oe;
		logic [31:0] r;
		logic e;
		apb(1'b1, 8'h58, 32'h13, r, e);
		repeat (2) @(posedge clk);
		chk("seen on", seen, 32'h1);
		apb(1'b0, 8'h88, 32'h0, r, e);
		chk("status", r, {26'h0, lk, 2'h3});
		apb(1'b1, 8'h58, 32'h12, r, e);
		repeat (2) @(posedge clk);
		chk("oe_n off", oe_n, 32'h1);
		chk("seen off", seen, 32'h0);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("lvl reset", lvl, 32'h0);
		chk("oe_n reset", oe_n, 32'h1);
		apb(1'b0, 8'h58, 32'h0, r, e);
		chk("ctl reset", r, 32'h0);
		$display("t_oe done");
	endtask : t_oe
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out
	// hang guard, about twice the expected run of roughly a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc > 2000) begin
			bad_count++;
			close_out;
		end
	end
	initial begin
		drive(41'h0);
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs;
		t_sweep;
		t_oe;
		close_out;
	end
endmodule : gpomx_top_bench
bind gpomx_top gpomx_sva i_sva (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
	.PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .GPIO6_LEVEL_O(GPIO6_LEVEL_O),
	.GPIO6_OE_N_O(GPIO6_OE_N_O));
`default_nettype wire
